// File: logic/lmsc_cfg.svh
// Functional notes
// - short prepare: id bit5 clear, 0x82, node
// - long prepare: 0x3C, 0x80, 0x82, node, FFs
// - reading frame 0x7D returns requested OTP data
// - OTP bytes in order; the third byte (index 2) packs address
// - hardwired bits come from pins, location 0x02
// - quick status: two bytes, switch/node then flags
// - status read clears latched flags unless persisting
// - quick status id is dynamically allocated
// - dynamic ids carry checked parity bits
// - 0x84 command moves to stored safe position
// - safe move also on link loss, init end
// - broadcast bit zero: every node moves
// - safe position 0x400 disables every safe move
// - coil fault raises internal halt, bridges off
// - coil fault while moving sets lost step
// - 0x85 command halts the motor
// - broadcast bit zero: every node halts
`ifndef LMSC_CFG_SVH
`define LMSC_CFG_SVH

// ****************************************
// frame identifiers and command codes
// ****************************************
`define LMSC_ID_DIAG_REQ    8'h3C
`define LMSC_ID_DIAG_RESP   8'h7D
`define LMSC_APP_CMD        8'h80
`define LMSC_FILLER         8'hFF
`define LMSC_CMD_READ_OTP   7'h02
`define LMSC_CMD_GO_SAFE    7'h04
`define LMSC_CMD_HALT       7'h05
`define LMSC_SAFE_DISABLED  11'h400

// ****************************************
// frame lengths and positions
// ****************************************
`define LMSC_OTP_RESP_LEN   4'h8
`define LMSC_STATUS_LEN     4'h2
`define LMSC_DIAG_LEN       4'h8
`define LMSC_OTP_ADDR_LOC   3'h2
`define LMSC_OTP_DEPTH      8

`endif

// File: logic/lmsc_otp_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsc_cfg.svh"

module lmsc_otp_mem (
    input  wire logic       clk,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data_q
);

    logic [7:0] mem_q [0:`LMSC_OTP_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // registered read keeps the response byte off a long mux path
    always_ff @(posedge clk) begin
        rd_data_q <= mem_q[rd_addr];
    end

endmodule
`default_nettype wire

// File: logic/lmsc_pkg.sv
`default_nettype none
package lmsc_pkg;

    typedef struct packed {
        logic supply_reset;
        logic lost_step;
        logic coil_defect;
        logic undervoltage;
        logic thermal_shutdown;
        logic thermal_warning;
        logic charge_pump_fail;
        logic coil1_overcurrent;
        logic coil2_overcurrent;
    } lmsc_flags_t;

    typedef struct packed {
        logic [4:0] prepare_id;
        logic [4:0] status_id;
        logic [4:0] write_id;
    } lmsc_ids_t;

    typedef enum logic [2:0] {
        FK_NONE,
        FK_PREPARE,
        FK_DIAG,
        FK_WRITE,
        FK_OTP_READ,
        FK_STATUS
    } lmsc_kind_t;

endpackage
`default_nettype wire

// File: logic/lmsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmsc_cfg.svh"

module lmsc_top
    import lmsc_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        RX_ID_VALID,
    input  wire logic [7:0]  RX_ID,
    input  wire logic        RX_DATA_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_FRAME_END,
    input  wire logic        TX_REQ,
    output logic      [7:0]  TX_DATA,
    output logic             TX_VALID,
    output logic             TX_ACTIVE,
    output logic             ID_PARITY_ERR,
    input  wire lmsc_ids_t   FRAME_IDS,
    input  wire logic [6:0]  NODE_ADDR,
    input  wire logic [2:0]  HW_ADDR_PINS,
    input  wire logic        OTP_WR_EN,
    input  wire logic [2:0]  OTP_WR_ADDR,
    input  wire logic [7:0]  OTP_WR_DATA,
    input  wire logic [10:0] SAFE_POSITION,
    input  wire logic        EXT_SWITCH,
    input  wire logic [1:0]  TEMP_INFO,
    input  wire lmsc_flags_t FAULT_COND,
    input  wire logic        COIL_FAULT,
    input  wire logic        MOTOR_MOVING,
    input  wire logic        LIN_LOST,
    input  wire logic        INIT_RUN_DONE,
    output lmsc_flags_t      FLAGS,
    output logic             GO_SAFE,
    output logic      [10:0] SAFE_TARGET,
    output logic             HALT,
    output logic             BRIDGE_OFF
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] protect_id(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    function automatic logic node_hit(input logic [7:0] sel, input logic [6:0] node,
                                      input logic bcast_ok);
        return (bcast_ok && !sel[7]) || (sel[7] && sel[6:0] == node);
    endfunction

    function automatic logic dyn_match(input logic [7:0] id, input logic [4:0] alloc);
        return id == protect_id({1'b0, alloc});
    endfunction

    function automatic logic dyn_bad(input logic [7:0] id, input logic [4:0] alloc);
        return id[5:0] == {1'b0, alloc} && id != protect_id({1'b0, alloc});
    endfunction

    // ****************************************
    // pin synchroniser for hardwired address
    // ****************************************
    logic [2:0] hw_meta_q;
    logic [2:0] hw_addr_q;

    always_ff @(posedge REF_CLK) begin
        hw_meta_q <= HW_ADDR_PINS;
        hw_addr_q <= hw_meta_q;
    end

    // ****************************************
    // frame decode
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} lmsc_state_t;

    lmsc_state_t      state_q;
    lmsc_kind_t       kind_q;
    lmsc_kind_t       kind_d;
    logic [3:0]       cnt_q;
    logic [7:0][7:0]  rx_q;
    logic             otp_pending_q;
    logic             any_bad;

    always_comb begin
        kind_d  = FK_NONE;
        any_bad = dyn_bad(RX_ID, FRAME_IDS.prepare_id) || dyn_bad(RX_ID, FRAME_IDS.status_id)
                  || dyn_bad(RX_ID, FRAME_IDS.write_id);
        if (RX_ID == `LMSC_ID_DIAG_REQ) begin
            kind_d = FK_DIAG;
        end else if (RX_ID == `LMSC_ID_DIAG_RESP) begin
            kind_d = otp_pending_q ? FK_OTP_READ : FK_NONE;
        end else if (dyn_match(RX_ID, FRAME_IDS.status_id)) begin
            kind_d = FK_STATUS;
        end else if (dyn_match(RX_ID, FRAME_IDS.prepare_id)) begin
            kind_d = FK_PREPARE;
        end else if (dyn_match(RX_ID, FRAME_IDS.write_id)) begin
            kind_d = FK_WRITE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            kind_q  <= FK_NONE;
        end else if (RX_ID_VALID) begin
            kind_q <= kind_d;
            unique case (kind_d)
                FK_OTP_READ, FK_STATUS: state_q <= ST_TX;
                FK_NONE:                state_q <= ST_IDLE;
                FK_PREPARE, FK_DIAG, FK_WRITE: state_q <= ST_RX;
            endcase
        end else if (RX_FRAME_END) begin
            state_q <= ST_IDLE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ID_PARITY_ERR <= 1'b0;
        end else begin
            ID_PARITY_ERR <= RX_ID_VALID && any_bad;
        end
    end

    // counts received bytes in ST_RX and sent bytes in ST_TX
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cnt_q <= 4'h0;
        end else if (RX_ID_VALID) begin
            cnt_q <= 4'h0;
        end else if (state_q == ST_RX && RX_DATA_VALID && cnt_q < `LMSC_DIAG_LEN) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (state_q == ST_TX && TX_REQ && TX_ACTIVE) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rx_q <= '0;
        end else if (state_q == ST_RX && RX_DATA_VALID && cnt_q < `LMSC_DIAG_LEN) begin
            rx_q[cnt_q[2:0]] <= RX_DATA;
        end
    end

    // ****************************************
    // command evaluation at frame end
    // ****************************************
    logic rx_done;
    logic short_prep_ok;
    logic long_prep_ok;
    logic fillers_ok;
    logic cmd_safe;
    logic cmd_halt;
    logic status_served;
    logic otp_served;

    assign rx_done    = state_q == ST_RX && RX_FRAME_END;
    assign fillers_ok = rx_q[3] == `LMSC_FILLER && rx_q[4] == `LMSC_FILLER
                        && rx_q[5] == `LMSC_FILLER && rx_q[6] == `LMSC_FILLER
                        && rx_q[7] == `LMSC_FILLER;

    assign short_prep_ok = rx_done && kind_q == FK_PREPARE && cnt_q == 4'h2
                           && rx_q[0] == {1'b1, `LMSC_CMD_READ_OTP}
                           && node_hit(rx_q[1], NODE_ADDR, 1'b0);
    assign long_prep_ok  = rx_done && kind_q == FK_DIAG && cnt_q == `LMSC_DIAG_LEN
                           && rx_q[0] == `LMSC_APP_CMD
                           && rx_q[1] == {1'b1, `LMSC_CMD_READ_OTP}
                           && node_hit(rx_q[2], NODE_ADDR, 1'b0) && fillers_ok;
    assign cmd_safe = rx_done && kind_q == FK_WRITE && cnt_q == 4'h2
                      && rx_q[0] == {1'b1, `LMSC_CMD_GO_SAFE}
                      && node_hit(rx_q[1], NODE_ADDR, 1'b1);
    assign cmd_halt = rx_done && kind_q == FK_WRITE && cnt_q == 4'h2
                      && rx_q[0] == {1'b1, `LMSC_CMD_HALT}
                      && node_hit(rx_q[1], NODE_ADDR, 1'b1);
    assign status_served = state_q == ST_TX && RX_FRAME_END && kind_q == FK_STATUS;
    assign otp_served    = state_q == ST_TX && RX_FRAME_END && kind_q == FK_OTP_READ;

    // a new prepare wins over the end of an earlier read
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            otp_pending_q <= 1'b0;
        end else if (short_prep_ok || long_prep_ok) begin
            otp_pending_q <= 1'b1;
        end else if (otp_served) begin
            otp_pending_q <= 1'b0;
        end
    end

    // ****************************************
    // response bytes
    // ****************************************
    logic [7:0] otp_rd_q;
    logic [3:0] tx_len;
    logic       tx_stage_q;
    logic [2:0] tx_idx_q;
    logic [7:0] tx_byte;

    assign tx_len    = kind_q == FK_STATUS ? `LMSC_STATUS_LEN : `LMSC_OTP_RESP_LEN;
    assign TX_ACTIVE = state_q == ST_TX && cnt_q < tx_len;

    lmsc_otp_mem u_otp (
        .clk       (REF_CLK),
        .wr_en     (OTP_WR_EN),
        .wr_addr   (OTP_WR_ADDR),
        .wr_data   (OTP_WR_DATA),
        .rd_addr   (cnt_q[2:0]),
        .rd_data_q (otp_rd_q)
    );

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            tx_stage_q <= 1'b0;
            tx_idx_q   <= 3'h0;
        end else begin
            tx_stage_q <= TX_REQ && TX_ACTIVE;
            tx_idx_q   <= cnt_q[2:0];
        end
    end

    always_comb begin
        tx_byte = otp_rd_q;
        if (kind_q == FK_STATUS) begin
            tx_byte = tx_idx_q == 3'h0 ? {EXT_SWITCH, NODE_ADDR}
                    : {FLAGS.supply_reset, FLAGS.lost_step, FLAGS.coil_defect,
                       FLAGS.undervoltage, FLAGS.thermal_shutdown, FLAGS.thermal_warning,
                       TEMP_INFO};
        end else if (tx_idx_q == `LMSC_OTP_ADDR_LOC) begin
            tx_byte = {otp_rd_q[7], hw_addr_q, otp_rd_q[3:0]};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            TX_DATA  <= 8'h00;
            TX_VALID <= 1'b0;
        end else begin
            TX_VALID <= tx_stage_q;
            if (tx_stage_q) begin
                TX_DATA <= tx_byte;
            end
        end
    end

    // ****************************************
    // latched fault flags
    // ****************************************
    logic coil_fault_q;
    logic coil_rise;

    assign coil_rise = COIL_FAULT && !coil_fault_q;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            coil_fault_q <= 1'b0;
        end else begin
            coil_fault_q <= COIL_FAULT;
        end
    end

    // a persisting condition sets in the same cycle as the clear, so it stays
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            FLAGS <= '0;
        end else begin
            FLAGS <= (status_served ? '0 : FLAGS) | FAULT_COND;
            if (coil_rise && MOTOR_MOVING) begin
                FLAGS.lost_step <= 1'b1;
            end
        end
    end

    // ****************************************
    // motion requests
    // ****************************************
    logic safe_enabled;

    assign safe_enabled = SAFE_POSITION != `LMSC_SAFE_DISABLED;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            GO_SAFE     <= 1'b0;
            SAFE_TARGET <= 11'h000;
        end else begin
            GO_SAFE <= safe_enabled && (cmd_safe || LIN_LOST || INIT_RUN_DONE);
            if (safe_enabled) begin
                SAFE_TARGET <= SAFE_POSITION;
            end
        end
    end

    // bridges stay off until the next safe move is requested
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            HALT       <= 1'b0;
            BRIDGE_OFF <= 1'b0;
        end else begin
            HALT <= cmd_halt || coil_rise;
            if (cmd_halt || coil_rise) begin
                BRIDGE_OFF <= 1'b1;
            end else if (GO_SAFE) begin
                BRIDGE_OFF <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_safe_disabled_quiet: assert property (
        SAFE_POSITION == `LMSC_SAFE_DISABLED |=> !GO_SAFE)
        else $error("safe move issued while disabled");
    a_link_loss_move: assert property (
        LIN_LOST && SAFE_POSITION != `LMSC_SAFE_DISABLED |=> GO_SAFE)
        else $error("no safe move after link loss");
    a_coil_halt_out: assert property (
        $rose(COIL_FAULT) |=> HALT && BRIDGE_OFF)
        else $error("coil fault did not halt");
    a_lost_step_set: assert property (
        $rose(COIL_FAULT) && MOTOR_MOVING |=> FLAGS.lost_step)
        else $error("lost step not set on moving fault");
    a_flag_persists: assert property (
        status_served && FAULT_COND.thermal_warning |=> FLAGS.thermal_warning)
        else $error("persisting flag was cleared");
    a_flag_cleared: assert property (
        status_served && !FAULT_COND.undervoltage |=> !FLAGS.undervoltage)
        else $error("flag not cleared by status read");
    a_halt_cmd_stop: assert property (
        cmd_halt |=> HALT ##1 !HALT)
        else $error("halt command not one pulse");
    a_otp_after_prep: assert property (
        short_prep_ok || long_prep_ok |=> otp_pending_q)
        else $error("prepare did not arm reading frame");
    a_status_two_bytes: assert property (
        state_q == ST_TX && kind_q == FK_STATUS && cnt_q == `LMSC_STATUS_LEN |-> !TX_ACTIVE)
        else $error("status frame longer than two bytes");
    a_tx_latency: assert property (
        TX_REQ && TX_ACTIVE |-> ##2 TX_VALID)
        else $error("response byte latency wrong");
    a_parity_flag: assert property (
        RX_ID_VALID && any_bad |=> ID_PARITY_ERR)
        else $error("bad parity not reported");

    c_otp_read: cover property (otp_served);
    c_status_read: cover property (status_served);
    c_safe_cmd: cover property (cmd_safe ##1 GO_SAFE);
    c_moving_fault: cover property ($rose(COIL_FAULT) && MOTOR_MOVING);

endmodule
`default_nettype wire

// File: verification/lmsc_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
$display("unexpected %s exp %h got %h", nm, e, g); end end

module lmsc_bench
    import lmsc_pkg::*;
;
    logic        REF_CLK = 1'h0;
    logic        RESET, RX_ID_VALID, RX_DATA_VALID, RX_FRAME_END, TX_REQ;
    logic        TX_VALID, TX_ACTIVE, ID_PARITY_ERR, EXT_SWITCH, COIL_FAULT, MOTOR_MOVING;
    logic        LIN_LOST, INIT_RUN_DONE, GO_SAFE, HALT, BRIDGE_OFF, OTP_WR_EN;
    logic [7:0]  RX_ID, RX_DATA, TX_DATA, OTP_WR_DATA;
    logic [6:0]  NODE_ADDR, nd;
    logic [2:0]  HW_ADDR_PINS, OTP_WR_ADDR;
    logic [10:0] SAFE_POSITION, SAFE_TARGET;
    logic [1:0]  TEMP_INFO;
    lmsc_flags_t FAULT_COND, FLAGS, expf;
    lmsc_ids_t   FRAME_IDS;
    logic [7:0]  otp [8];
    int          failures, checks_done, n_safe, n_halt, n_perr, n_act, cyc, k, c, e, act;

    lmsc_top DUT (.REF_CLK(REF_CLK), .RESET(RESET), .RX_ID_VALID(RX_ID_VALID), .RX_ID(RX_ID),
        .RX_DATA_VALID(RX_DATA_VALID), .RX_DATA(RX_DATA), .RX_FRAME_END(RX_FRAME_END),
        .TX_REQ(TX_REQ), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_ACTIVE(TX_ACTIVE),
        .ID_PARITY_ERR(ID_PARITY_ERR), .FRAME_IDS(FRAME_IDS), .NODE_ADDR(NODE_ADDR),
        .HW_ADDR_PINS(HW_ADDR_PINS), .OTP_WR_EN(OTP_WR_EN), .OTP_WR_ADDR(OTP_WR_ADDR),
        .OTP_WR_DATA(OTP_WR_DATA), .SAFE_POSITION(SAFE_POSITION), .EXT_SWITCH(EXT_SWITCH),
        .TEMP_INFO(TEMP_INFO), .FAULT_COND(FAULT_COND), .COIL_FAULT(COIL_FAULT),
        .MOTOR_MOVING(MOTOR_MOVING), .LIN_LOST(LIN_LOST), .INIT_RUN_DONE(INIT_RUN_DONE),
        .FLAGS(FLAGS), .GO_SAFE(GO_SAFE), .SAFE_TARGET(SAFE_TARGET), .HALT(HALT),
        .BRIDGE_OFF(BRIDGE_OFF));

    lmsc_master_model m (.clk(REF_CLK), .id_valid(RX_ID_VALID), .id(RX_ID),
        .data_valid(RX_DATA_VALID), .data(RX_DATA), .frame_end(RX_FRAME_END),
        .tx_req(TX_REQ), .tx_data(TX_DATA), .tx_valid(TX_VALID));

    always #5 REF_CLK = ~REF_CLK;

    // pulse counters, plus the hang guard
    always @(posedge REF_CLK) begin
        cyc++;
        n_safe += (GO_SAFE === 1'h1);
        n_halt += (HALT === 1'h1);
        n_perr += (ID_PARITY_ERR === 1'h1);
        n_act += (TX_REQ === 1'h1 && TX_ACTIVE === 1'h1);
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic new_ids();
        FRAME_IDS.status_id = 5'($urandom);
        FRAME_IDS.prepare_id = FRAME_IDS.status_id ^ 5'h1;
        FRAME_IDS.write_id = FRAME_IDS.status_id ^ 5'h2;
    endtask

    task automatic wr(input logic [6:0] cmd, input logic [7:0] b1);
        m.frame(m.prot(FRAME_IDS.write_id), {1'h1, cmd, b1, 48'h0}, 2, 0);
        repeat (3) @(posedge REF_CLK);
        #1;
    endtask

    // one request beyond the two owed bytes must be refused
    task automatic stat();
        m.frame(m.prot(FRAME_IDS.status_id), 64'h0, 0, 3);
    endtask

    // otp byte two carries the pin address in place of stored bits
    function automatic logic [7:0] exp_otp(input int a);
        return (a == 2) ? {otp[2][7], HW_ADDR_PINS, otp[2][3:0]} : otp[a];
    endfunction

    initial begin
        {OTP_WR_EN, OTP_WR_ADDR, OTP_WR_DATA, COIL_FAULT, MOTOR_MOVING} = '0;
        {LIN_LOST, INIT_RUN_DONE, FAULT_COND, failures, checks_done} = '0;
        {n_safe, n_halt, n_perr, n_act, cyc} = '0;
        RESET = 1'h1;
        k = $urandom(32'hc2e2);
        NODE_ADDR = 7'($urandom);
        HW_ADDR_PINS = 3'($urandom);
        {EXT_SWITCH, TEMP_INFO} = 3'($urandom);
        SAFE_POSITION = 11'h155;
        new_ids();
        repeat (10) @(posedge REF_CLK);
        #1 RESET = 1'h0;
        for (k = 0; k < 8; k++) begin
            otp[k] = 8'($urandom);
            OTP_WR_EN = 1'h1;
            OTP_WR_ADDR = 3'(k);
            OTP_WR_DATA = otp[k];
            @(posedge REF_CLK) #1;
        end
        OTP_WR_EN = 1'h0;
        // ****************************************
        // otp read: short, long, then wrong node
        // ****************************************
        for (c = 0; c < 4; c++) begin
            HW_ADDR_PINS = 3'($urandom);
            e = (c == 3) ? 0 : 8;
            nd = (c == 3) ? ~NODE_ADDR : NODE_ADDR;
            if (c[0])
                m.frame(8'h3C, {16'h8082, 1'h1, nd, 40'hFF_FFFF_FFFF}, 8, 0);
            else
                m.frame(m.prot(FRAME_IDS.prepare_id), {8'h82, 1'h1, nd, 48'h0}, 2, 0);
            act = n_act;
            m.frame(8'h7D, 64'h0, 0, 8);
            `CHK("otp count", e, m.got)
            `CHK("otp accepted", e, n_act - act)
            for (k = 0; k < e; k++)
                `CHK("otp byte", exp_otp(k), m.rsp[k])
        end
        // ****************************************
        // quick status and flag clearing
        // ****************************************
        expf = '0;
        for (c = 0; c < 4; c++) begin
            new_ids();
            {EXT_SWITCH, TEMP_INFO} = 3'($urandom);
            FAULT_COND = lmsc_flags_t'(9'($urandom));
            @(posedge REF_CLK) #1;
            expf = expf | FAULT_COND;
            FAULT_COND = FAULT_COND & lmsc_flags_t'(9'($urandom));
            @(posedge REF_CLK) #1;
            `CHK("flags", expf, FLAGS)
            act = n_act;
            stat();
            `CHK("status count", 2, m.got)
            `CHK("status accepted", 2, n_act - act)
            `CHK("status byte0", {EXT_SWITCH, NODE_ADDR}, m.rsp[0])
            `CHK("status byte1", {expf[8:3], TEMP_INFO}, m.rsp[1])
            expf = FAULT_COND;
            repeat (2) @(posedge REF_CLK);
            #1;
            `CHK("flags kept", expf, FLAGS)
            FAULT_COND = '0;
        end
        // bad parity must be flagged and leave flags alone
        e = n_perr;
        m.frame(m.prot(FRAME_IDS.status_id) ^ 8'h80, 64'h0, 0, 2);
        `CHK("bad parity rsp", 0, m.got)
        `CHK("parity errs", e + 1, n_perr)
        `CHK("flags untouched", expf, FLAGS)
        // ****************************************
        // safe move and halt: broadcast, match, miss, disabled
        // ****************************************
        for (c = 0; c < 8; c++) begin
            SAFE_POSITION = (c[1:0] == 2'h3) ? 11'h400 : {1'h0, 10'($urandom)};
            act = (c[1:0] != 2'h2) && !(c[1:0] == 2'h3 && !c[2]);
            k = n_safe;
            e = n_halt;
            nd = (c[1:0] == 2'h1) ? NODE_ADDR : ~NODE_ADDR;
            wr(c[2] ? 7'h05 : 7'h04, {c[1:0] == 2'h1 || c[1:0] == 2'h2, nd});
            `CHK("safe moves", k + (!c[2] && act), n_safe)
            `CHK("halts", e + (c[2] && act), n_halt)
            if (!c[2] && act)
                `CHK("safe target", SAFE_POSITION, SAFE_TARGET)
        end
        // ****************************************
        // coil fault halt and internal safe triggers
        // ****************************************
        e = n_halt;
        {MOTOR_MOVING, COIL_FAULT} = 2'h3;
        repeat (3) @(posedge REF_CLK);
        #1;
        `CHK("coil halt", e + 1, n_halt)
        `CHK("bridge off", 1'h1, BRIDGE_OFF)
        `CHK("lost step", 1'h1, FLAGS.lost_step)
        {MOTOR_MOVING, COIL_FAULT} = 2'h0;
        for (c = 0; c < 4; c++) begin
            SAFE_POSITION = c[1] ? 11'h400 : 11'h2AA;
            k = n_safe;
            {LIN_LOST, INIT_RUN_DONE} = c[0] ? 2'h1 : 2'h2;
            @(posedge REF_CLK) #1;
            {LIN_LOST, INIT_RUN_DONE} = 2'h0;
            repeat (3) @(posedge REF_CLK);
            #1;
            `CHK("internal safe", k + !c[1], n_safe)
        end
        `CHK("bridge released", 1'h0, BRIDGE_OFF)
        stat();
        `CHK("lost step read", 1'h1, m.rsp[1][6])
        wrap_up();
    end
endmodule

`default_nettype wire

// File: verification/lmsc_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// lin master stand-in
// ****************************************
module lmsc_master_model (
    input  wire logic       clk,
    output logic            id_valid,
    output logic      [7:0] id,
    output logic            data_valid,
    output logic      [7:0] data,
    output logic            frame_end,
    output logic            tx_req,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid
);
    logic [7:0] rsp [8];
    int         got;

    initial begin
        id_valid = 1'h0;
        id = 8'h00;
        data_valid = 1'h0;
        data = 8'h00;
        frame_end = 1'h0;
        tx_req = 1'h0;
    end

    function automatic logic [7:0] prot(input logic [4:0] i);
        return {~(i[1] ^ i[3] ^ i[4]), i[0] ^ i[1] ^ i[2] ^ i[4], 1'h0, i};
    endfunction

    // idle lines show the inverse of the last value, not a stale copy
    task automatic frame(input logic [7:0] fid, input logic [63:0] b, input int n, input int nr);
        int k;
        @(posedge clk) #1;
        id_valid = 1'h1;
        id = fid;
        @(posedge clk) #1;
        id_valid = 1'h0;
        id = ~fid;
        for (k = 0; k < n; k++) begin
            data_valid = 1'h1;
            data = b[63 - 8 * k -: 8];
            @(posedge clk) #1;
        end
        data_valid = 1'h0;
        data = ~data;
        got = 0;
        for (k = 0; k < nr; k++) begin
            tx_req = 1'h1;
            @(posedge clk) #1;
            tx_req = 1'h0;
            repeat (3) begin
                @(posedge clk) #1;
                if (tx_valid === 1'h1 && got < 8) begin
                    rsp[got] = tx_data;
                    got++;
                end
            end
        end
        frame_end = 1'h1;
        @(posedge clk) #1;
        frame_end = 1'h0;
    endtask
endmodule

`default_nettype wire
